// >>> phc_pkg.sv
// phc_pkg: constants and types for the pll holdover / vco calibration block
// assumes: register port and pins described in phc_top
`default_nettype none
package phc_pkg;
    // register offsets (10-bit address space)
    localparam logic [9:0] ADDR_LDCAL  = 10'h018;
    localparam logic [9:0] ADDR_LDPIN  = 10'h01A;
    localparam logic [9:0] ADDR_REFSEL = 10'h01C;
    localparam logic [9:0] ADDR_HOLD   = 10'h01D;
    localparam logic [9:0] ADDR_RDBK   = 10'h01F;
    localparam logic [9:0] ADDR_CH0    = 10'h191;
    localparam logic [9:0] ADDR_CH1    = 10'h194;
    localparam logic [9:0] ADDR_CH2    = 10'h197;
    localparam logic [9:0] ADDR_CH3    = 10'h19A;
    localparam logic [9:0] ADDR_VCODIV = 10'h1E0;
    localparam logic [9:0] ADDR_XFER   = 10'h232;
    // field positions
    localparam int B_CAL_START = 0;  // lock/cal reg
    localparam int B_CALDIV_LO = 1;  // two bits
    localparam int B_DLD_DIS   = 3;
    localparam int B_LDCNT_LO  = 5;  // two bits
    localparam int B_MON_EXT   = 6;  // ld pin reg
    localparam int B_HOLD_EN   = 0;  // holdover reg
    localparam int B_HOLD_EXT  = 1;
    localparam int B_CMP_EN    = 3;
    localparam int B_IGN_ALIGN = 6;  // channel regs
    localparam int B_XFER      = 0;
    localparam int B_RB_DLD    = 0;  // readback reg
    localparam int B_RB_LDSENS = 1;
    localparam int B_RB_MON    = 2;  // three bits
    localparam int B_RB_HOLD   = 5;
    localparam int B_RB_CALOK  = 6;
    localparam logic [5:0] LDPIN_CURRENT_SOURCE_LOCK_FLAG = 6'h04;
    localparam logic [7:0] REG_RST     = 8'h00;
    // lock detect counts per two-bit code
    localparam logic [7:0] LDCNT_0 = 8'h05;
    localparam logic [7:0] LDCNT_1 = 8'h0A;
    localparam logic [7:0] LDCNT_2 = 8'h14;
    localparam logic [7:0] LDCNT_3 = 8'h28;
    // calibration length in calibration clocks
    localparam int CAL_CYCLES = 4400;
    // cal sequencer states
    typedef enum logic [1:0] {
        CAL_IDLE  = 2'b00,
        CAL_RUN   = 2'b01,
        CAL_UNALN = 2'b10,
        CAL_CLOSE = 2'b11
    } phc_cal_t;
    // software-visible register set
    typedef struct packed {
        logic [7:0] ldCal;
        logic [7:0] ldPin;
        logic [7:0] refSel;
        logic [7:0] hold;
        logic [3:0][7:0] chan;
        logic [7:0] vcoDiv;
    } phc_regs_t;
    // synchronised pin levels
    typedef struct packed {
        logic       alignPinN;
        logic       lockPin;
        logic       refEdge;
        logic       inWin;
        logic       overUnl;
        logic [4:0] mon;
    } phc_pins_t;
endpackage : phc_pkg
`default_nettype wire

// >>> phc_top.sv
// phc_top: holdover control, digital lock flag and vco calibration sequencer
// assumes: one 10 MHz clock; register port driven by same-clock serial
// logic; pins other than autoLoadDone arrive asynchronously and are synchronised here
`default_nettype none
module phc_top #(
    parameter int CAL_LEN = phc_pkg::CAL_CYCLES  // shorten in simulation
) (
    input  wire logic                   clk,
    input  wire logic                   reset,
    input  wire logic                   ce,          // freezes all state
    input  wire logic                   regWrite,    // write strobe
    input  wire logic                   regRead,     // read strobe
    input  wire logic [9:0]             regAddr,
    input  wire logic [7:0]             regWrData,
    output logic      [7:0]             regRdData,   // valid cycle after read
    input  wire logic                   autoLoadDone,// store load finished
    input  wire logic                   alignPinN,   // alignment pin, low act
    input  wire logic                   lockPin,     // lock indicator level
    input  wire logic                   refEdgeIn,   // detector ref clock
    input  wire logic                   inLockWin,   // edge diff under lock
    input  wire logic                   overUnlock,  // edge diff over unlock
    input  wire logic [4:0]             monRaw,      // low-freq detects
    output logic                        cpHighZ,     // charge pump tristate
    output logic                        bCntReset,   // one-cycle pulse
    output logic      [3:0]             chanOff,     // channel outputs off
    output logic                        alignHold,   // internal alignment
    output logic                        loopOpen,    // loop open for cal
    output logic                        calDone,
    output logic                        digitalLockFlag,
    output logic                        csdldSelect, // current-source mode
    output logic      [2:0]             monFlags     // first_reference, second_reference, vco low
);
    // whole module state
    typedef struct packed {
        phc_pkg::phc_regs_t buff;      // written by software
        phc_pkg::phc_regs_t act;       // in force after transfer
        phc_pkg::phc_pins_t s1;        // first sync stage
        phc_pkg::phc_pins_t s2;        // second sync stage
        logic               alignPrev; // for edge detect
        logic               refPrev;
        logic               hold;
        logic               holdManual;
        logic               armed;
        logic [7:0]         lockCnt;
        logic               digital_lock_flag;
        phc_pkg::phc_cal_t  calState;
        logic [4:0]         calDivCnt;
        logic [12:0]        calCnt;
        logic               calOk;
        logic               bReset;
        logic [3:0]         chOff;
        logic [7:0]         rd;
        logic               current_source_lock_flag;
        logic [2:0]         mon;
        logic               alignH;    // cal running, registered
        logic               loopOp;    // cal not idle, registered
    } phc_state_t;

    phc_state_t st_r;              // registered state
    phc_state_t st_nxt;            // next state

    // locals of the combinational process
    logic       refEvt;
    logic       alignFall;
    logic       lockSense;
    logic       xfer;
    logic       calStart;
    logic       calTick;
    logic [7:0] lockNeed;
    logic [4:0] calDivLen;
    logic [1:0] calDivCode;
    logic [1:0] ldCode;
    phc_pkg::phc_pins_t pinsNow;

    // pins bundled for the synchroniser
    always_comb begin
        pinsNow = '{alignPinN: alignPinN, lockPin: lockPin,
                    refEdge: refEdgeIn, inWin: inLockWin,
                    overUnl: overUnlock, mon: monRaw};
    end

    // next-state logic
    always_comb begin
        st_nxt = st_r;
        // two-stage synchroniser; stage one read only here
        st_nxt.s1 = pinsNow;
        st_nxt.s2 = st_r.s1;
        st_nxt.alignPrev = st_r.s2.alignPinN;
        st_nxt.refPrev = st_r.s2.refEdge;
        refEvt = st_r.s2.refEdge & ~st_r.refPrev;
        alignFall = st_r.alignPrev & ~st_r.s2.alignPinN;
        st_nxt.bReset = 1'b0;

        // register writes into the buffer set
        xfer = 1'b0;
        if (regWrite) begin
            unique case (regAddr)
                phc_pkg::ADDR_LDCAL:  st_nxt.buff.ldCal = regWrData;
                phc_pkg::ADDR_LDPIN:  st_nxt.buff.ldPin = regWrData;
                phc_pkg::ADDR_REFSEL: st_nxt.buff.refSel = regWrData;
                phc_pkg::ADDR_HOLD:   st_nxt.buff.hold = regWrData;
                phc_pkg::ADDR_CH0:    st_nxt.buff.chan[0] = regWrData;
                phc_pkg::ADDR_CH1:    st_nxt.buff.chan[1] = regWrData;
                phc_pkg::ADDR_CH2:    st_nxt.buff.chan[2] = regWrData;
                phc_pkg::ADDR_CH3:    st_nxt.buff.chan[3] = regWrData;
                phc_pkg::ADDR_VCODIV: st_nxt.buff.vcoDiv = regWrData;
                phc_pkg::ADDR_XFER:   xfer = regWrData[phc_pkg::B_XFER];
                default:              ; // unmapped writes ignored
            endcase
        end
        // transfer strobe makes buffered values take effect
        if (xfer) begin
            st_nxt.act = st_r.buff;
        end
        // a start bit rising into force begins a cal
        calStart = (xfer & st_r.buff.ldCal[phc_pkg::B_CAL_START] &
                    ~st_r.act.ldCal[phc_pkg::B_CAL_START])
                   | autoLoadDone;

        // lock indicator as the holdover logic sees it
        lockSense = st_r.act.hold[phc_pkg::B_CMP_EN] ?
                    st_r.s2.lockPin : 1'b1;

        // digital lock flag, judged once per detector cycle
        ldCode = st_r.act.ldCal[phc_pkg::B_LDCNT_LO +: 2];
        unique case (ldCode)
            2'b00:   lockNeed = phc_pkg::LDCNT_0;
            2'b01:   lockNeed = phc_pkg::LDCNT_1;
            2'b10:   lockNeed = phc_pkg::LDCNT_2;
            default: lockNeed = phc_pkg::LDCNT_3;
        endcase
        if (st_r.act.ldCal[phc_pkg::B_DLD_DIS]) begin
            st_nxt.digital_lock_flag = 1'b0;
            st_nxt.lockCnt = 8'h00;
        end else if (refEvt) begin
            if (st_r.s2.overUnl) begin
                // one bad cycle drops lock at once
                st_nxt.digital_lock_flag = 1'b0;
                st_nxt.lockCnt = 8'h00;
            end else if (st_r.s2.inWin) begin
                if (st_r.lockCnt + 8'h01 >= lockNeed) begin
                    st_nxt.digital_lock_flag = 1'b1;
                    st_nxt.lockCnt = lockNeed;
                end else begin
                    st_nxt.lockCnt = st_r.lockCnt + 8'h01;
                end
            end else begin
                // between windows: run broken, flag kept
                st_nxt.lockCnt = 8'h00;
            end
        end

        // holdover: one tristate from both sources
        if (!st_r.act.hold[phc_pkg::B_HOLD_EN]) begin
            st_nxt.hold = 1'b0;
            st_nxt.holdManual = 1'b0;
            st_nxt.armed = 1'b1;
        end else begin
            // release waits for a ref edge; none means stay high-z
            if (st_r.hold && refEvt &&
                (!st_r.holdManual || st_r.s2.alignPinN)) begin
                st_nxt.hold = 1'b0;
                st_nxt.bReset = 1'b1;
            end
            // entry: alignment pin fall in external mode, else lock lost while armed; entry beats release
            if (st_r.act.hold[phc_pkg::B_HOLD_EXT]) begin
                if (alignFall) begin
                    st_nxt.hold = 1'b1;
                    st_nxt.holdManual = 1'b1;
                    st_nxt.bReset = 1'b0;
                end
            end else if (st_r.armed && !lockSense) begin
                st_nxt.hold = 1'b1;
                st_nxt.holdManual = 1'b0;
                st_nxt.armed = 1'b0;
                st_nxt.bReset = 1'b0;
            end
            // re-arm once lock is indicated again
            if (!st_r.armed && !st_r.hold && lockSense) begin
                st_nxt.armed = 1'b1;
            end
        end

        // calibration clock: detector events divided down
        calDivCode = st_r.act.ldCal[phc_pkg::B_CALDIV_LO +: 2];
        unique case (calDivCode)
            2'b00:   calDivLen = 5'd2;
            2'b01:   calDivLen = 5'd4;
            2'b10:   calDivLen = 5'd8;
            default: calDivLen = 5'd16;
        endcase
        calTick = 1'b0;
        if (refEvt) begin
            if (st_r.calDivCnt + 5'd1 >= calDivLen) begin
                st_nxt.calDivCnt = 5'd0;
                calTick = 1'b1;
            end else begin
                st_nxt.calDivCnt = st_r.calDivCnt + 5'd1;
            end
        end

        // calibration sequencer
        unique case (st_r.calState)
            phc_pkg::CAL_IDLE: begin
                if (calStart) begin
                    st_nxt.calState = phc_pkg::CAL_RUN;
                    st_nxt.calCnt = 13'd0;
                    st_nxt.calDivCnt = 5'd0;
                    st_nxt.calOk = 1'b0;
                end
            end
            phc_pkg::CAL_RUN: begin
                // no reference means no ticks: cal simply waits
                if (calTick) begin
                    if (st_r.calCnt + 13'd1 >= 13'(CAL_LEN)) begin
                        st_nxt.calState = phc_pkg::CAL_UNALN;
                    end else begin
                        st_nxt.calCnt = st_r.calCnt + 13'd1;
                    end
                end
            end
            phc_pkg::CAL_UNALN: begin
                // outputs resume before the loop closes
                st_nxt.calState = phc_pkg::CAL_CLOSE;
            end
            phc_pkg::CAL_CLOSE: begin
                st_nxt.calState = phc_pkg::CAL_IDLE;
                st_nxt.calOk = 1'b1;
            end
        endcase

        // flopped copies of the next cal state drive the pins
        st_nxt.alignH = (st_nxt.calState == phc_pkg::CAL_RUN);
        st_nxt.loopOp = (st_nxt.calState != phc_pkg::CAL_IDLE);
        // channel gating from the alignment pin and the cal
        for (int i = 0; i < 4; i++) begin
            st_nxt.chOff[i] = (!st_r.s2.alignPinN &&
                !st_r.act.chan[i][phc_pkg::B_IGN_ALIGN])
                || (st_r.calState == phc_pkg::CAL_RUN);
        end

        // lock pin mode decode
        st_nxt.current_source_lock_flag = (st_r.act.ldPin[5:0] ==
                        phc_pkg::LDPIN_CURRENT_SOURCE_LOCK_FLAG);

        // monitors: ref flags pick normal or extended input
        st_nxt.mon[0] = st_r.act.ldPin[phc_pkg::B_MON_EXT] ?
                        st_r.s2.mon[1] : st_r.s2.mon[0];
        st_nxt.mon[1] = st_r.act.ldPin[phc_pkg::B_MON_EXT] ?
                        st_r.s2.mon[3] : st_r.s2.mon[2];
        st_nxt.mon[2] = st_r.s2.mon[4];

        // read data, registered; unmapped reads zero
        if (regRead) begin
            unique case (regAddr)
                phc_pkg::ADDR_LDCAL:  st_nxt.rd = st_r.buff.ldCal;
                phc_pkg::ADDR_LDPIN:  st_nxt.rd = st_r.buff.ldPin;
                phc_pkg::ADDR_REFSEL: st_nxt.rd = st_r.buff.refSel;
                phc_pkg::ADDR_HOLD:   st_nxt.rd = st_r.buff.hold;
                phc_pkg::ADDR_CH0:    st_nxt.rd = st_r.buff.chan[0];
                phc_pkg::ADDR_CH1:    st_nxt.rd = st_r.buff.chan[1];
                phc_pkg::ADDR_CH2:    st_nxt.rd = st_r.buff.chan[2];
                phc_pkg::ADDR_CH3:    st_nxt.rd = st_r.buff.chan[3];
                phc_pkg::ADDR_VCODIV: st_nxt.rd = st_r.buff.vcoDiv;
                phc_pkg::ADDR_RDBK: begin
                    st_nxt.rd = 8'h00;
                    st_nxt.rd[phc_pkg::B_RB_DLD] = st_r.digital_lock_flag;
                    st_nxt.rd[phc_pkg::B_RB_LDSENS] = lockSense;
                    st_nxt.rd[phc_pkg::B_RB_MON +: 3] = st_r.mon;
                    st_nxt.rd[phc_pkg::B_RB_HOLD] = st_r.hold;
                    st_nxt.rd[phc_pkg::B_RB_CALOK] = st_r.calOk;
                end
                default:              st_nxt.rd = 8'h00;
            endcase
        end
    end

    // state register; ce low freezes everything
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_r <= '0;
            st_r.armed <= 1'b1;
            st_r.s1.alignPinN <= 1'b1;
            st_r.s2.alignPinN <= 1'b1;
            st_r.alignPrev <= 1'b1;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from state flops
    always_comb begin
        regRdData = st_r.rd;
        cpHighZ = st_r.hold;
        bCntReset = st_r.bReset;
        chanOff = st_r.chOff;
        alignHold = st_r.alignH;
        loopOpen = st_r.loopOp;
        calDone = st_r.calOk;
        digitalLockFlag = st_r.digital_lock_flag;
        csdldSelect = st_r.current_source_lock_flag;
        monFlags = st_r.mon;
    end
endmodule : phc_top
`default_nettype wire

// >>> phc_partner.sv
// phc_partner: host-side model that drives alignment pin and reference
// assumes: shares the bench clock; reference stands low while switched off
`default_nettype none
module phc_partner #(
    parameter int REF_HALF = 3  // reference half period in clk cycles
) (
    input  wire logic clk,
    input  wire logic refOn,
    input  wire logic alignLow,
    output logic      refEdgeIn,
    output logic      alignPinN
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt;  // half-period counter
    initial begin
        refEdgeIn = 1'b0;
        alignPinN = 1'b1;
        cnt = 0;
    end
    // stable reference well under the cal clock limit
    always @(posedge clk) begin
        alignPinN <= #1 ~alignLow;
        cnt = (cnt + 1) % REF_HALF;
        if (!refOn)
            refEdgeIn <= #1 1'b0;  // absent reference does not toggle
        else if (cnt == 0)
            refEdgeIn <= #1 ~refEdgeIn;
    end
endmodule : phc_partner
`default_nettype wire

// >>> phc_top_assertions.sv
// phc_top_assertions: port-level timing checks for phc_top
// assumes: bench holds ce high; one clock domain; bound at file foot
`default_nettype none
module phc_top_assertions #(
    parameter int CAL_LEN = phc_pkg::CAL_CYCLES  // same as design
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic refEdgeIn,
    input wire logic cpHighZ,
    input wire logic bCntReset,
    input wire logic alignHold,
    input wire logic loopOpen,
    input wire logic calDone
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic [15:0] runLen_r;  // cycles with alignment held
    logic [3:0]  refAge_r;  // cycles since raw reference rose
    logic        refDly_r;  // reference one cycle ago
    // saturating counters so a stalled run cannot wrap
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            runLen_r <= 16'h0000;
            refAge_r <= 4'hF;
            refDly_r <= 1'b0;
        end else begin
            refDly_r <= refEdgeIn;
            if (!alignHold)
                runLen_r <= 16'h0000;
            else if (runLen_r != 16'hFFFF)
                runLen_r <= runLen_r + 16'h0001;
            if (refEdgeIn && !refDly_r)
                refAge_r <= 4'h0;
            else if (refAge_r != 4'hF)
                refAge_r <= refAge_r + 4'h1;
        end
    end
    sequence s_unalign;
        !alignHold && loopOpen;
    endsequence
    sequence s_close;
        loopOpen ##1 (!loopOpen && calDone);
    endsequence
    a_release_pulse: assert property (
        bCntReset |-> $fell(cpHighZ)) else $error("counter reset off release");
    a_pulse_single: assert property (
        bCntReset |=> !bCntReset) else $error("counter reset too long");
    a_release_pair: assert property (
        $fell(cpHighZ) |-> bCntReset) else $error("release without reset");
    a_release_ref: assert property (
        $fell(cpHighZ) |-> refAge_r < 4'h8) else $error("release w/o ref");
    a_hold_open: assert property (
        alignHold |-> loopOpen) else $error("alignment with loop closed");
    a_cal_tail: assert property (
        $fell(alignHold) |-> s_unalign ##1 s_close)
        else $error("bad calibration end order");
    a_cal_length: assert property (
        $fell(alignHold) |-> runLen_r >= 16'(2 * CAL_LEN))
        else $error("calibration too short");
    a_done_rise: assert property (
        $rose(calDone) |-> $fell(loopOpen)) else $error("done off loop close");
    a_done_clear: assert property (
        $fell(calDone) |-> ##[0:2] loopOpen) else $error("done cleared idle");
endmodule : phc_top_assertions
bind phc_top phc_top_assertions #(
    .CAL_LEN (CAL_LEN)
) u_phcChk (
    .clk       (clk),
    .reset     (reset),
    .refEdgeIn (refEdgeIn),
    .cpHighZ   (cpHighZ),
    .bCntReset (bCntReset),
    .alignHold (alignHold),
    .loopOpen  (loopOpen),
    .calDone   (calDone)
);
`default_nettype wire

// >>> testbench.sv
// testbench: scenarios for phc_top against the host partner model
// assumes: ce held high; partner drives reference and alignment pin
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int CAL_LEN = 5;   // shortened calibration
    localparam int REF_HALF = 3;  // reference period 6 cycles
    logic clk = 1'b0, reset = 1'b1, ce = 1'b1, refOn = 1'b0, alignLow = 1'b0;
    logic regWrite = 1'b0, regRead = 1'b0, autoLoadDone = 1'b0;
    logic lockPin = 1'b1, inLockWin = 1'b0, overUnlock = 1'b0;
    logic [9:0] regAddr = 10'h000;
    logic [7:0] regWrData = 8'h00;
    logic [4:0] monRaw = 5'h00;
    logic refEdgeIn, alignPinN, cpHighZ, bCntReset, alignHold, loopOpen;
    logic calDone, digitalLockFlag, csdldSelect;
    logic [7:0] regRdData;
    logic [3:0] chanOff;
    logic [2:0] monFlags;
    int numErrors = 0, comparisons = 0, cycles = 0;
    always #50 clk = ~clk;  // 10 MHz
    phc_top #(.CAL_LEN(CAL_LEN)) i_dut (.clk(clk), .reset(reset), .ce(ce),
        .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
        .regWrData(regWrData), .regRdData(regRdData),
        .autoLoadDone(autoLoadDone), .alignPinN(alignPinN), .lockPin(lockPin),
        .refEdgeIn(refEdgeIn), .inLockWin(inLockWin), .overUnlock(overUnlock),
        .monRaw(monRaw), .cpHighZ(cpHighZ), .bCntReset(bCntReset),
        .chanOff(chanOff), .alignHold(alignHold), .loopOpen(loopOpen),
        .calDone(calDone), .digitalLockFlag(digitalLockFlag),
        .csdldSelect(csdldSelect), .monFlags(monFlags));
    phc_partner #(.REF_HALF(REF_HALF)) i_host (.clk(clk), .refOn(refOn),
        .alignLow(alignLow), .refEdgeIn(refEdgeIn), .alignPinN(alignPinN));
    task automatic endSim;
        if (numErrors == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : endSim
    // hang guard: whole run needs a few thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            numErrors++;
            endSim();
        end
    end
    task automatic chk(input string what, input logic [7:0] exp, got);
        comparisons++;
        if (got !== exp) begin
            numErrors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // strobe dropped a full cycle so back-to-back calls never collide
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        regAddr = a;
        regWrData = d;
        regWrite = 1'b1;
        tick(1);
        regWrite = 1'b0;
        tick(1);
    endtask : wr
    task automatic setReg(input logic [9:0] a, input logic [7:0] d);
        wr(a, d);
        wr(phc_pkg::ADDR_XFER, 8'h01);
        tick(2);
    endtask : setReg
    task automatic rd(input logic [9:0] a, input logic [7:0] e,
                      input string s);
        regAddr = a;
        regRead = 1'b1;
        tick(1);
        regRead = 1'b0;
        tick(1);
        chk(s, e, regRdData);
    endtask : rd
    task automatic tRegs;
        logic [9:0] adr [4] = '{phc_pkg::ADDR_LDCAL, phc_pkg::ADDR_HOLD,
            phc_pkg::ADDR_CH3, phc_pkg::ADDR_XFER};
        foreach (adr[i]) rd(adr[i], 8'h00, "reset value");
        rd(phc_pkg::ADDR_RDBK, 8'h02, "readback");
        wr(phc_pkg::ADDR_RDBK, 8'hFF);
        rd(phc_pkg::ADDR_RDBK, 8'h02, "read only");
        rd(10'h3FF, 8'h00, "unmapped");
        wr(phc_pkg::ADDR_REFSEL, 8'hA5);
        rd(phc_pkg::ADDR_REFSEL, 8'hA5, "refsel");
        wr(phc_pkg::ADDR_REFSEL, 8'h00);
    endtask : tRegs
    task automatic tMon;
        setReg(phc_pkg::ADDR_LDPIN, 8'h04);
        chk("current_source_lock_flag", 8'h01, {7'h00, csdldSelect});
        monRaw = 5'h02;  // first_reference below extended threshold only
        tick(8);
        chk("mon normal", 8'h00, {5'h00, monFlags});
        setReg(phc_pkg::ADDR_LDPIN, 8'h40);
        tick(4);
        chk("mon ext", 8'h01, {5'h00, monFlags});
        monRaw = 5'h10;
        tick(8);
        chk("mon vco", 8'h04, {5'h00, monFlags});
        monRaw = 5'h00;
        setReg(phc_pkg::ADDR_LDPIN, 8'h00);
    endtask : tMon
    // one calibration per divider code, length from ref period and code
    task automatic runCal(input logic [1:0] code);
        int n, e, div;
        n = 0;
        div = 2 << code;
        e = CAL_LEN * 2 * REF_HALF * div;
        setReg(phc_pkg::ADDR_LDCAL, 8'h00);
        setReg(phc_pkg::ADDR_LDCAL, {5'h00, code, 1'b1});
        for (int i = 0; i < 9 && !alignHold; i++) tick(1);
        chk("chan static", 8'h0F, {4'h0, chanOff});
        while (alignHold && n < 900) begin
            n++;
            tick(1);
        end
        chk("cal length", 8'h01,
            8'(n >= e - 2 * REF_HALF * div && n < e + 12));
        tick(3);
        chk("cal done", 8'h01, {7'h00, calDone});
    endtask : runCal
    task automatic tCal;
        refOn = 1'b1;
        wr(phc_pkg::ADDR_VCODIV, 8'h01);  // never static
        setReg(phc_pkg::ADDR_LDCAL, 8'h01);
        for (int i = 0; i < 9 && !alignHold; i++) tick(1);
        chk("first cal", 8'h03, {6'h00, alignHold, loopOpen});
        for (int i = 0; i < 200 && !calDone; i++) tick(1);
        rd(phc_pkg::ADDR_RDBK, 8'h42, "done bit");
        for (int c = 0; c < 4; c++) runCal(2'(c));
        setReg(phc_pkg::ADDR_LDCAL, 8'h01);
        tick(9);
        chk("no restart", 8'h00, {7'h00, loopOpen});
        setReg(phc_pkg::ADDR_LDCAL, 8'h00);
        refOn = 1'b0;
        setReg(phc_pkg::ADDR_LDCAL, 8'h01);
        tick(200);
        chk("stall", 8'h02, {6'h00, alignHold, calDone});
        refOn = 1'b1;
        for (int i = 0; i < 200 && !calDone; i++) tick(1);
        autoLoadDone = 1'b1;
        tick(1);
        autoLoadDone = 1'b0;
        for (int i = 0; i < 9 && !loopOpen; i++) tick(1);
        chk("auto load cal", 8'h01, {7'h00, loopOpen});
        for (int i = 0; i < 200 && !calDone; i++) tick(1);
        chk("auto load done", 8'h01, {7'h00, calDone});
    endtask : tCal
    task automatic tLock;
        @(negedge refEdgeIn);
        #1;
        inLockWin = 1'b1;
        repeat (4) @(posedge refEdgeIn);
        tick(5);
        chk("lock 4", 8'h00, {7'h00, digitalLockFlag});
        tick(6);
        chk("lock 5", 8'h01, {7'h00, digitalLockFlag});
        overUnlock = 1'b1;
        tick(3);
        @(posedge refEdgeIn);
        tick(6);
        chk("unlock", 8'h00, {7'h00, digitalLockFlag});
        // code 01 wants ten; count starts clean after the bad cycles
        setReg(phc_pkg::ADDR_LDCAL, 8'h21);
        @(negedge refEdgeIn);
        #1;
        overUnlock = 1'b0;
        repeat (9) @(posedge refEdgeIn);
        tick(5);
        chk("lock 9", 8'h00, {7'h00, digitalLockFlag});
        tick(6);
        chk("lock 10", 8'h01, {7'h00, digitalLockFlag});
        setReg(phc_pkg::ADDR_LDCAL, 8'h29);
        chk("lock disabled", 8'h00, {7'h00, digitalLockFlag});
        setReg(phc_pkg::ADDR_LDCAL, 8'h01);
        inLockWin = 1'b0;
    endtask : tLock
    task automatic tManual;
        refOn = 1'b0;
        setReg(phc_pkg::ADDR_HOLD, 8'h02);
        alignLow = 1'b1;
        tick(8);
        chk("hz disabled", 8'h00, {7'h00, cpHighZ});
        chk("chan off", 8'h0F, {4'h0, chanOff});
        for (int c = 0; c < 4; c++) begin
            setReg(phc_pkg::ADDR_CH0 + 10'(3 * c), 8'h40);
        end
        chk("chan ignore", 8'h00, {4'h0, chanOff});
        setReg(phc_pkg::ADDR_HOLD, 8'h03);
        tick(8);
        chk("level ignored", 8'h00, {7'h00, cpHighZ});
        alignLow = 1'b0;
        tick(8);
        alignLow = 1'b1;
        tick(6);
        chk("manual entry", 8'h01, {7'h00, cpHighZ});
        alignLow = 1'b0;
        tick(40);
        chk("held no ref", 8'h01, {7'h00, cpHighZ});
        refOn = 1'b1;
        for (int i = 0; i < 40 && cpHighZ; i++) tick(1);
        chk("exit", 8'h01, {6'h00, cpHighZ, bCntReset});
    endtask : tManual
    task automatic tAuto;
        refOn = 1'b0;
        setReg(phc_pkg::ADDR_HOLD, 8'h09);
        lockPin = 1'b0;
        for (int i = 0; i < 12 && !cpHighZ; i++) tick(1);
        chk("auto entry", 8'h01, {7'h00, cpHighZ});
        tick(40);
        chk("auto held", 8'h01, {7'h00, cpHighZ});
        refOn = 1'b1;
        for (int i = 0; i < 40 && cpHighZ; i++) tick(1);
        chk("cp free", 8'h01, {6'h00, cpHighZ, bCntReset});
        tick(30);
        chk("no rearm", 8'h00, {7'h00, cpHighZ});
        lockPin = 1'b1;
        tick(8);
        lockPin = 1'b0;
        for (int i = 0; i < 12 && !cpHighZ; i++) tick(1);
        chk("rearmed", 8'h01, {7'h00, cpHighZ});
        lockPin = 1'b1;
        setReg(phc_pkg::ADDR_HOLD, 8'h01);
        for (int i = 0; i < 12 && cpHighZ; i++) tick(1);
        refOn = 1'b0;  // a false entry would now stick
        tick(4);
        lockPin = 1'b0;
        tick(12);
        chk("comparator off", 8'h00, {7'h00, cpHighZ});
    endtask : tAuto
    initial begin
        repeat (6) @(posedge clk);
        #1;
        reset = 1'b0;
        tRegs();
        tMon();
        tCal();
        tLock();
        tManual();
        tAuto();
        endSim();
    end
endmodule : testbench
`default_nettype wire
